// File: ccce_pkg.sv
// Summary of operation
// R1: masks and class association are readable and writable at any time, no quiet period.
// R2: a write that sets any reserved bit raises a protection fault, error code zero.
// R3: any mask access above the highest supported class raises a protection fault.
// R4: writing a class above the largest supported maximum class faults.
// R5: reading the association returns the class currently programmed for that processor.
// R6: reading mask n returns the capacity bitmask now in effect for class n.
// R7: power-saving cache shrink overrides the bitmasks for the affected storage.
// R8: after the cache returns from shrink, new fills follow the requesting class bitmask.
// R9: lines held before shrink or power-off may be flushed on idle entry.
// R10: association is saved on deep core idle entry and restored on exit.
// R11: mask contents survive package idle entry and exit.
// R12: a management interrupt leaves association and all masks unchanged.
// R13: enforcement is only an allocation hint and never touches coherency.
// R14: software wanting full determinism should disable cache-shrinking power features.
// R15: a management handler may switch to a reserved class and restore it at exit.
// R16: each processor has its own association at its address, class in 63:32, reset 0.
// R17: masks fill a 256-slot address range, class n at the nth slot.
// R18: the class 0 mask resets to all ones, unrestricted allocation.
// R19: the maximum class value is zero based, 15 means sixteen classes.
// R20: a faulting write leaves the targeted register unchanged.
// R21: fills use the bitmask of the class in the issuing processor's association.
package ccce_pkg;

  // ==========================================================================
  // register map
  localparam int ADDR_W = 12;
  localparam int DATA_W = 64;
  localparam logic [ADDR_W-1:0] ASSOC_ADDR = 12'hC8F;
  localparam logic [ADDR_W-1:0] MASK_BASE = 12'hC90;
  localparam logic [ADDR_W-1:0] MASK_LAST = 12'hD8F;
  localparam int MASK_SLOT_W = 8;
  localparam int CLASS_LSB = 32;
  localparam int CLASS_W = 32;
  localparam int ASSOC_RSV_W = 32;

  // ==========================================================================
  // reset values and defaults
  localparam logic [CLASS_W-1:0] ASSOC_CLASS_RST = 32'h0000_0000;
  localparam logic MASK_RST_BIT = 1'b1;
  localparam int DEF_MAX_CLASS = 15;
  localparam int DEF_CBM_LEN = 16;
  localparam int DEF_NUM_LP = 2;

  // ==========================================================================
  // per-processor idle tracking
  typedef enum logic [1:0] {
    CCCE_ACTIVE = 2'b01,
    CCCE_PARKED = 2'b10
  } ccce_idle_t;

  // ==========================================================================
  // address decode
  function automatic logic ccce_is_mask(input logic [ADDR_W-1:0] addr);
    ccce_is_mask = (addr >= MASK_BASE) && (addr <= MASK_LAST);
  endfunction

  function automatic logic [MASK_SLOT_W-1:0] ccce_slot(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] diff;
    diff = addr - MASK_BASE;
    ccce_slot = diff[MASK_SLOT_W-1:0];
  endfunction

endpackage

// File: ccce_mask_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ccce_mask_if #(
  parameter int CBM_LEN = 16,
  parameter int IDX_W = 4
);
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [CBM_LEN-1:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [CBM_LEN-1:0] rd_data;
  logic [IDX_W-1:0] fill_idx;
  logic [CBM_LEN-1:0] fill_data;

  modport store (
    input wr_en,
    input wr_idx,
    input wr_data,
    input rd_idx,
    input fill_idx,
    output rd_data,
    output fill_data
  );

  modport user (
    output wr_en,
    output wr_idx,
    output wr_data,
    output rd_idx,
    output fill_idx,
    input rd_data,
    input fill_data
  );
endinterface
`default_nettype wire

// File: ccce_mask_store.sv
`timescale 1ns/1ps
`default_nettype none
module ccce_mask_store #(
  parameter int NUM_CLASSES = 16,
  parameter int CBM_LEN = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  ccce_mask_if.store bus
);

  logic [CBM_LEN-1:0] mask_r [NUM_CLASSES];

  // ==========================================================================
  // mask storage
  // no idle or interrupt input reaches this array, so contents are retained
  // R11: retained across package idle
  // R18: reset to all ones
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < NUM_CLASSES; i++)
      begin
        mask_r[i] <= {CBM_LEN{ccce_pkg::MASK_RST_BIT}};
      end
    end
    else if (bus.wr_en)
    begin
      mask_r[bus.wr_idx] <= bus.wr_data;
    end
  end

  // R6: current mask read
  assign bus.rd_data = mask_r[bus.rd_idx];
  // R21: mask of the issuing class
  assign bus.fill_data = mask_r[bus.fill_idx];

endmodule
`default_nettype wire

// File: ccce_top.sv
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ccce_top #(
  parameter int MAX_CLASS = ccce_pkg::DEF_MAX_CLASS,
  parameter int CBM_LEN = ccce_pkg::DEF_CBM_LEN,
  parameter int NUM_LP = ccce_pkg::DEF_NUM_LP,
  parameter int LP_W = (NUM_LP > 1) ? $clog2(NUM_LP) : 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [ccce_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [ccce_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [LP_W-1:0] reg_lp_i,
  output logic [ccce_pkg::DATA_W-1:0] reg_rdata_o,
  output logic reg_fault_o,
  input wire logic [NUM_LP-1:0] core_idle_i,
  input wire logic pkg_idle_i,
  input wire logic mgmt_interrupt_i,
  input wire logic pwr_shrink_i,
  input wire logic [CBM_LEN-1:0] pwr_avail_mask_i,
  input wire logic fill_req_i,
  input wire logic [LP_W-1:0] fill_lp_i,
  output logic fill_valid_o,
  output logic [CBM_LEN-1:0] fill_mask_o,
  output logic flush_req_o
);

  // ==========================================================================
  // sizing
  // the class index is zero based, so MAX_CLASS 15 stores sixteen masks
  // R19: zero-based class count
  localparam int NUM_CLASSES = MAX_CLASS + 1;
  localparam int IDX_W = (NUM_CLASSES > 1) ? $clog2(NUM_CLASSES) : 1;
  localparam logic [ccce_pkg::CLASS_W-1:0] MAX_CLASS_W = ccce_pkg::CLASS_W'(MAX_CLASS);
  localparam logic [ccce_pkg::MASK_SLOT_W-1:0] MAX_SLOT = ccce_pkg::MASK_SLOT_W'(MAX_CLASS);
  localparam int MASK_RSV_W = ccce_pkg::DATA_W - CBM_LEN;

  // ==========================================================================
  // declarations
  ccce_mask_if #(.CBM_LEN(CBM_LEN), .IDX_W(IDX_W)) mask_bus ();

  logic [IDX_W-1:0] assoc_r [NUM_LP];
  logic [IDX_W-1:0] save_r [NUM_LP];
  ccce_pkg::ccce_idle_t idle_st_r [NUM_LP];
  logic [IDX_W-1:0] lp_class [NUM_LP];

  logic hit_assoc;
  logic hit_mask;
  logic [ccce_pkg::MASK_SLOT_W-1:0] slot;
  logic slot_ok;
  logic [ccce_pkg::CLASS_W-1:0] wr_class;
  logic assoc_rsv_bad;
  logic mask_rsv_bad;
  logic assoc_wr_fault;
  logic mask_wr_fault;
  logic access_fault;
  logic assoc_wr_ok;
  logic mask_wr_ok;
  logic [CBM_LEN-1:0] fill_mask_nxt;
  logic [CBM_LEN-1:0] shrunk_mask;
  logic shrink_q_r;
  logic pkg_idle_q_r;
  logic class_bad;
  logic range_bad;
  logic [ccce_pkg::DATA_W-1:0] rdata_nxt;
  logic shrink_rise;
  logic pkg_idle_rise;

  // ==========================================================================
  // mask storage
  ccce_mask_store #(
    .NUM_CLASSES(NUM_CLASSES),
    .CBM_LEN(CBM_LEN)
  ) u_store (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .bus(mask_bus)
  );

  // ==========================================================================
  // access decode and checks
  assign hit_assoc = (reg_addr_i == ccce_pkg::ASSOC_ADDR);
  assign hit_mask = ccce_pkg::ccce_is_mask(reg_addr_i);
  assign slot = ccce_pkg::ccce_slot(reg_addr_i);
  // R17: class n at slot n
  assign slot_ok = (slot <= MAX_SLOT);
  assign wr_class = reg_wdata_i[ccce_pkg::CLASS_LSB +: ccce_pkg::CLASS_W];

  // reserved bits read as zero, so any set bit would change one
  // R2: reserved bit check
  assign assoc_rsv_bad = (reg_wdata_i[ccce_pkg::ASSOC_RSV_W-1:0] != '0);
  // R2: reserved mask bits
  assign mask_rsv_bad = (reg_wdata_i[ccce_pkg::DATA_W-1 -: MASK_RSV_W] != '0);

  // single resource type, so its maximum is also the largest over all
  // R4: class above maximum
  assign class_bad = hit_assoc && (wr_class > MAX_CLASS_W);
  // R3: slot beyond supported class
  assign range_bad = hit_mask && !slot_ok;

  assign assoc_wr_fault = hit_assoc && (assoc_rsv_bad || class_bad);
  assign mask_wr_fault = hit_mask && (mask_rsv_bad || range_bad);
  // a read faults only on range; reserved bits matter to writes alone
  assign access_fault = (reg_we_i && (assoc_wr_fault || mask_wr_fault))
                     || (reg_re_i && range_bad);

  // R20: faulting write stores nothing
  assign assoc_wr_ok = reg_we_i && hit_assoc && !assoc_wr_fault;
  assign mask_wr_ok = reg_we_i && hit_mask && !mask_wr_fault;

  // R1: write at any time
  assign mask_bus.wr_en = mask_wr_ok;
  assign mask_bus.wr_idx = slot[IDX_W-1:0];
  assign mask_bus.wr_data = reg_wdata_i[CBM_LEN-1:0];
  assign mask_bus.rd_idx = slot[IDX_W-1:0];

  // ==========================================================================
  // per-processor association
  genvar g;
  generate
    for (g = 0; g < NUM_LP; g++)
    begin : g_lp
      logic lp_sel;
      logic lp_wr;
      logic enter_idle;
      logic leave_idle;
      assign lp_sel = (reg_lp_i == LP_W'(g));
      assign lp_wr = assoc_wr_ok && lp_sel;
      // entry and exit are judged on the edge at which the state changes
      assign enter_idle = (idle_st_r[g] == ccce_pkg::CCCE_ACTIVE) && core_idle_i[g];
      assign leave_idle = (idle_st_r[g] == ccce_pkg::CCCE_PARKED) && !core_idle_i[g];

      // while parked the live copy is lost and the saved copy is the truth
      assign lp_class[g] = (idle_st_r[g] == ccce_pkg::CCCE_PARKED) ? save_r[g] : assoc_r[g];

      // R10: save and restore across deep idle
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
        begin
          idle_st_r[g] <= ccce_pkg::CCCE_ACTIVE;
        end
        else
        begin
          unique case (idle_st_r[g])
            ccce_pkg::CCCE_ACTIVE:
            begin
              if (core_idle_i[g])
              begin
                idle_st_r[g] <= ccce_pkg::CCCE_PARKED;
              end
            end
            ccce_pkg::CCCE_PARKED:
            begin
              if (!core_idle_i[g])
              begin
                idle_st_r[g] <= ccce_pkg::CCCE_ACTIVE;
              end
            end
            default:
            begin
              idle_st_r[g] <= ccce_pkg::CCCE_ACTIVE;
            end
          endcase
        end
      end

      // R10: saved copy
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
        begin
          save_r[g] <= ccce_pkg::ASSOC_CLASS_RST[IDX_W-1:0];
        end
        else if (lp_wr)
        begin
          save_r[g] <= wr_class[IDX_W-1:0];
        end
        else if (enter_idle)
        begin
          save_r[g] <= assoc_r[g];
        end
      end

      // mgmt_interrupt_i deliberately reaches no state here
      // R12: untouched by management interrupt
      // R16: per-processor class, reset 0
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
        begin
          assoc_r[g] <= ccce_pkg::ASSOC_CLASS_RST[IDX_W-1:0];
        end
        else if (lp_wr)
        begin
          assoc_r[g] <= wr_class[IDX_W-1:0];
        end
        else if (enter_idle)
        begin
          assoc_r[g] <= ccce_pkg::ASSOC_CLASS_RST[IDX_W-1:0];
        end
        else if (leave_idle)
        begin
          assoc_r[g] <= save_r[g];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // read path
  // R5: programmed class returned
  always_comb
  begin
    rdata_nxt = '0;
    if (reg_re_i && hit_assoc)
    begin
      rdata_nxt = {ccce_pkg::CLASS_W'(lp_class[reg_lp_i]), {ccce_pkg::ASSOC_RSV_W{1'b0}}};
    end
    else if (reg_re_i && hit_mask && slot_ok)
    begin
      rdata_nxt = {{MASK_RSV_W{1'b0}}, mask_bus.rd_data};
    end
  end

  // data stand for one cycle only, then fall back to zero
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      reg_rdata_o <= '0;
    end
    else
    begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // R2: fault pulse, error code zero
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      reg_fault_o <= 1'b0;
    end
    else
    begin
      reg_fault_o <= access_fault;
    end
  end

  // ==========================================================================
  // fill allocation hint
  // the hint only narrows placement; nothing here gates snoops or coherency
  // R13: allocation hint only
  // R21: class of issuing processor
  assign mask_bus.fill_idx = lp_class[fill_lp_i];

  // if the class's ways are all powered off, the power state wins outright
  // R7: power shrink takes precedence
  assign shrunk_mask = mask_bus.fill_data & pwr_avail_mask_i;

  // R8: full bitmask once cache returns
  always_comb
  begin
    fill_mask_nxt = mask_bus.fill_data;
    if (pwr_shrink_i)
    begin
      fill_mask_nxt = (shrunk_mask != '0) ? shrunk_mask : pwr_avail_mask_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      fill_valid_o <= 1'b0;
    end
    else
    begin
      fill_valid_o <= fill_req_i;
    end
  end

  // the mask holds between fills so a late reader still sees the last hint
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      fill_mask_o <= '0;
    end
    else if (fill_req_i)
    begin
      fill_mask_o <= fill_mask_nxt;
    end
  end

  // ==========================================================================
  // flush request on shrink or package idle entry
  // both edge detectors reset low, the idle level of their inputs, so no
  // false flush follows reset
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      shrink_q_r <= 1'b0;
    end
    else
    begin
      shrink_q_r <= pwr_shrink_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pkg_idle_q_r <= 1'b0;
    end
    else
    begin
      pkg_idle_q_r <= pkg_idle_i;
    end
  end

  assign shrink_rise = pwr_shrink_i && !shrink_q_r;
  assign pkg_idle_rise = pkg_idle_i && !pkg_idle_q_r;

  // resident lines are not guaranteed after resume; masks are not touched
  // R9: write back on idle entry
  // R11: masks kept through package idle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      flush_req_o <= 1'b0;
    end
    else
    begin
      flush_req_o <= shrink_rise || pkg_idle_rise;
    end
  end

endmodule
`default_nettype wire

// File: ccce_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ccce_top_sva #(
  parameter int MAX_CLASS = 15,
  parameter int CBM_LEN = 16,
  parameter int NUM_LP = 2,
  parameter int LP_W = 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [ccce_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [ccce_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [LP_W-1:0] reg_lp_i,
  input wire logic [ccce_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic reg_fault_o,
  input wire logic [NUM_LP-1:0] core_idle_i,
  input wire logic pkg_idle_i,
  input wire logic mgmt_interrupt_i,
  input wire logic pwr_shrink_i,
  input wire logic [CBM_LEN-1:0] pwr_avail_mask_i,
  input wire logic fill_req_i,
  input wire logic [LP_W-1:0] fill_lp_i,
  input wire logic fill_valid_o,
  input wire logic [CBM_LEN-1:0] fill_mask_o,
  input wire logic flush_req_o
);
  // ==========================================================================
  // address decode
  logic is_mask;
  logic unmapped;
  logic [ccce_pkg::ADDR_W-1:0] slot;
  assign is_mask = (reg_addr_i >= ccce_pkg::MASK_BASE) && (reg_addr_i <= ccce_pkg::MASK_LAST);
  assign unmapped = !is_mask && (reg_addr_i != ccce_pkg::ASSOC_ADDR);
  assign slot = reg_addr_i - ccce_pkg::MASK_BASE;

  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_mask_range_fault:
    assert property ((reg_we_i || reg_re_i) && is_mask && (slot > MAX_CLASS) |=> reg_fault_o)
    else $error("mask access beyond last class did not fault");
  a_mask_rsv_fault:
    assert property (reg_we_i && is_mask && ((reg_wdata_i >> CBM_LEN) != 64'h0) |=> reg_fault_o)
    else $error("mask write with reserved bits did not fault");
  a_class_max_fault:
    assert property (reg_we_i && (reg_addr_i == ccce_pkg::ASSOC_ADDR) && (reg_wdata_i[63:32] > MAX_CLASS)
      |=> reg_fault_o)
    else $error("class above maximum did not fault");
  a_fault_has_cause:
    assert property (reg_fault_o |-> $past(reg_we_i || reg_re_i))
    else $error("fault without a register strobe");
  a_rdata_idle_zero:
    assert property (!$past(reg_re_i) |-> reg_rdata_o == 64'h0)
    else $error("read data outside its answer cycle");
  a_unmapped_quiet:
    assert property ((reg_we_i || reg_re_i) && unmapped |=> !reg_fault_o && (reg_rdata_o == 64'h0))
    else $error("unmapped access answered");
  a_fill_one_cycle:
    assert property (fill_valid_o == $past(fill_req_i))
    else $error("fill answer not one cycle after request");
  a_fill_mask_hold:
    assert property (!fill_valid_o |-> $stable(fill_mask_o))
    else $error("fill mask changed without a fill");
  a_shrink_subset:
    assert property (fill_valid_o && $past(pwr_shrink_i) |-> (fill_mask_o & ~$past(pwr_avail_mask_i)) == '0)
    else $error("fill used powered-off units");
  a_flush_on_shrink:
    assert property ($rose(pwr_shrink_i) || $rose(pkg_idle_i) |=> flush_req_o)
    else $error("no flush after shrink or package idle");

  c_fill_shrunk: cover property (fill_req_i && pwr_shrink_i ##1 fill_valid_o);
  c_range_fault: cover property (reg_re_i && is_mask && (slot > MAX_CLASS) ##1 reg_fault_o);
  c_assoc_write: cover property (reg_we_i && (reg_addr_i == ccce_pkg::ASSOC_ADDR) ##1 !reg_fault_o);
endmodule

bind ccce_top ccce_top_sva #(.MAX_CLASS(MAX_CLASS), .CBM_LEN(CBM_LEN), .NUM_LP(NUM_LP), .LP_W(LP_W)) ccce_top_sva_inst (
  .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
  .reg_re_i(reg_re_i), .reg_lp_i(reg_lp_i), .reg_rdata_o(reg_rdata_o), .reg_fault_o(reg_fault_o),
  .core_idle_i(core_idle_i), .pkg_idle_i(pkg_idle_i), .mgmt_interrupt_i(mgmt_interrupt_i),
  .pwr_shrink_i(pwr_shrink_i), .pwr_avail_mask_i(pwr_avail_mask_i), .fill_req_i(fill_req_i),
  .fill_lp_i(fill_lp_i), .fill_valid_o(fill_valid_o), .fill_mask_o(fill_mask_o), .flush_req_o(flush_req_o)
);
`default_nettype wire

// File: tb_cache_class_capacity_enforcement.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cache_class_capacity_enforcement;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [11:0] reg_addr_i = 12'h000;
  logic [63:0] reg_wdata_i = 64'h0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [0:0] reg_lp_i = 1'b0;
  logic [63:0] reg_rdata_o;
  logic reg_fault_o;
  logic [1:0] core_idle_i = 2'b00;
  logic pkg_idle_i = 1'b0;
  logic mgmt_interrupt_i = 1'b0;
  logic pwr_shrink_i = 1'b0;
  logic [15:0] pwr_avail_mask_i = 16'hFFFF;
  logic fill_req_i = 1'b0;
  logic [0:0] fill_lp_i = 1'b0;
  logic fill_valid_o;
  logic [15:0] fill_mask_o;
  logic flush_req_o;
  logic [63:0] rd;
  logic flt;
  int num_errors = 0;
  int checks = 0;

  always #5 clk_i = ~clk_i;

  ccce_top #(.MAX_CLASS(15), .CBM_LEN(16), .NUM_LP(2)) ccce_top_inst (
    .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_lp_i(reg_lp_i), .reg_rdata_o(reg_rdata_o), .reg_fault_o(reg_fault_o),
    .core_idle_i(core_idle_i), .pkg_idle_i(pkg_idle_i), .mgmt_interrupt_i(mgmt_interrupt_i),
    .pwr_shrink_i(pwr_shrink_i), .pwr_avail_mask_i(pwr_avail_mask_i), .fill_req_i(fill_req_i),
    .fill_lp_i(fill_lp_i), .fill_valid_o(fill_valid_o), .fill_mask_o(fill_mask_o), .flush_req_o(flush_req_o)
  );

  // ==========================================================================
  // shared tasks
  function automatic logic [15:0] pat(input int n);
    pat = 16'h3C00 | 16'(n);
  endfunction

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one strobe cycle, answer taken in the following cycle
  task automatic bus(input logic we, input logic [11:0] a, input logic [63:0] d, input logic lp);
    @(posedge clk_i);
    reg_we_i <= we;
    reg_re_i <= !we;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_lp_i <= lp;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
    #1;
    rd = reg_rdata_o;
    flt = reg_fault_o;
  endtask

  task automatic fill(input logic lp, input logic [15:0] exp);
    @(posedge clk_i);
    fill_req_i <= 1'b1;
    fill_lp_i <= lp;
    @(posedge clk_i);
    fill_req_i <= 1'b0;
    #1;
    cmp({63'h0, fill_valid_o}, 64'h1);
    cmp({48'h0, fill_mask_o}, {48'h0, exp});
  endtask

  task automatic tick_flush();
    @(posedge clk_i);
    #1;
    cmp({63'h0, flush_req_o}, 64'h1);
    @(posedge clk_i);
    #1;
    cmp({63'h0, flush_req_o}, 64'h0);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    bus(1'b0, 12'hC8F, 64'h0, 1'b0);
    cmp(rd, 64'h0);
    bus(1'b0, 12'hC90, 64'h0, 1'b0);
    cmp(rd, 64'h0000_0000_0000_FFFF);
    fill(1'b0, 16'hFFFF);
  endtask

  task automatic t_masks();
    for (int n = 0; n < 16; n++)
    begin
      bus(1'b1, 12'hC90 + 12'(n), {48'h0, pat(n)}, 1'b0);
      cmp({63'h0, flt}, 64'h0);
    end
    for (int n = 0; n < 16; n++)
    begin
      bus(1'b0, 12'hC90 + 12'(n), 64'h0, 1'b0);
      cmp(rd, {48'h0, pat(n)});
    end
    bus(1'b0, 12'hCA0, 64'h0, 1'b0);
    cmp({rd[62:0], flt}, 64'h1);
    bus(1'b1, 12'hCA0, 64'h1, 1'b0);
    cmp({63'h0, flt}, 64'h1);
    bus(1'b1, 12'hC92, 64'h0001_0001, 1'b0);
    cmp({63'h0, flt}, 64'h1);
    bus(1'b0, 12'hC92, 64'h0, 1'b0);
    cmp(rd, {48'h0, pat(2)});
    bus(1'b1, 12'hC8E, 64'h5, 1'b0);
    bus(1'b0, 12'hC8E, 64'h0, 1'b0);
    cmp({rd[62:0], flt}, 64'h0);
  endtask

  task automatic t_assoc();
    bus(1'b1, 12'hC8F, {32'd5, 32'h0}, 1'b1);
    cmp({63'h0, flt}, 64'h0);
    bus(1'b0, 12'hC8F, 64'h0, 1'b1);
    cmp(rd, {32'd5, 32'h0});
    bus(1'b0, 12'hC8F, 64'h0, 1'b0);
    cmp(rd, 64'h0);
    bus(1'b1, 12'hC8F, {32'd16, 32'h0}, 1'b1);
    cmp({63'h0, flt}, 64'h1);
    bus(1'b1, 12'hC8F, {32'd3, 32'h1}, 1'b1);
    cmp({63'h0, flt}, 64'h1);
    bus(1'b0, 12'hC8F, 64'h0, 1'b1);
    cmp(rd, {32'd5, 32'h0});
    bus(1'b1, 12'hC8F, {32'd15, 32'h0}, 1'b0);
    cmp({63'h0, flt}, 64'h0);
    fill(1'b0, pat(15));
    fill(1'b1, pat(5));
  endtask

  task automatic t_shrink();
    @(posedge clk_i);
    pwr_avail_mask_i <= 16'h00F0;
    pwr_shrink_i <= 1'b1;
    tick_flush();
    fill(1'b1, 16'h00F0);
    @(posedge clk_i);
    pwr_avail_mask_i <= 16'h0C0F;
    fill(1'b1, 16'h0C05);
    @(posedge clk_i);
    pwr_shrink_i <= 1'b0;
    fill(1'b1, pat(5));
  endtask

  task automatic t_idle();
    @(posedge clk_i);
    core_idle_i <= 2'b10;
    repeat (2) @(posedge clk_i);
    bus(1'b0, 12'hC8F, 64'h0, 1'b1);
    cmp(rd, {32'd5, 32'h0});
    fill(1'b1, pat(5));
    @(posedge clk_i);
    core_idle_i <= 2'b00;
    bus(1'b0, 12'hC8F, 64'h0, 1'b1);
    cmp(rd, {32'd5, 32'h0});
    @(posedge clk_i);
    pkg_idle_i <= 1'b1;
    tick_flush();
    @(posedge clk_i);
    pkg_idle_i <= 1'b0;
    bus(1'b0, 12'hC95, 64'h0, 1'b0);
    cmp(rd, {48'h0, pat(5)});
    @(posedge clk_i);
    mgmt_interrupt_i <= 1'b1;
    bus(1'b0, 12'hC8F, 64'h0, 1'b1);
    cmp(rd, {32'd5, 32'h0});
    bus(1'b0, 12'hC95, 64'h0, 1'b0);
    cmp(rd, {48'h0, pat(5)});
    bus(1'b1, 12'hC8F, {32'd15, 32'h0}, 1'b1);
    cmp({63'h0, flt}, 64'h0);
    fill(1'b1, pat(15));
    bus(1'b1, 12'hC8F, {32'd5, 32'h0}, 1'b1);
    fill(1'b1, pat(5));
    @(posedge clk_i);
    mgmt_interrupt_i <= 1'b0;
  endtask

  task automatic t_reset_mid();
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    bus(1'b0, 12'hC8F, 64'h0, 1'b1);
    cmp(rd, 64'h0);
    bus(1'b0, 12'hC90, 64'h0, 1'b0);
    cmp(rd, 64'h0000_0000_0000_FFFF);
  endtask

  // ==========================================================================
  // run
  task automatic finish_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_masks();
    t_assoc();
    t_shrink();
    t_idle();
    t_reset_mid();
    finish_test();
  end
endmodule
`default_nettype wire
